// *** rtl/jtdr_consts.svh ***
`ifndef JTDR_CONSTS_SVH
`define JTDR_CONSTS_SVH
// chain length and positions of cells
`define JTDR_CHAIN_LEN 68
`define JTDR_ID_LEN 32
`define JTDR_POS_BUS_LO 46
`define JTDR_POS_BUS_HI 53
`define JTDR_POS_BUS_DIR 54
`define JTDR_POS_IRQ 38
`define JTDR_POS_IRQ_DIR 39
`define JTDR_POS_ADR_DIR 61
`define JTDR_POS_HWRST 36
`define JTDR_POS_SEL0 35
`define JTDR_POS_SEL1 55
`define JTDR_POS_BTYPE 34
// id code field values (arbitrary, neutral)
`define JTDR_ID_MFR 11'h2aa
`define JTDR_ID_DEV 16'h1234
`define JTDR_ID_VER 4'h1
`define JTDR_ID_MARK 1'h1
// instruction codes
`define JTDR_IR_EXTEST 3'h0
`define JTDR_IR_SAMPLE 3'h2
`define JTDR_IR_IDCODE 3'h3
`define JTDR_IR_BYPASS 3'h7
`endif

// *** rtl/jtdr_edge_if.sv ***
`timescale 1ns/1ns
// edge events of the test clock found by the sampler
interface jtdr_edge_if;
	logic rise; // test clock rising edge seen
	logic fall; // test clock falling edge seen
	logic tdi; // serial input, stable copy
	modport src (output rise, output fall, output tdi);
	modport dst (input rise, input fall, input tdi);
endinterface

// *** rtl/jtdr_pkg.sv ***
package jtdr_pkg;
	// test data register selection
	typedef enum logic [2:0] {
		JTDR_SEL_BYP = 3'h1,
		JTDR_SEL_ID = 3'h2,
		JTDR_SEL_BSR = 3'h4
	} jtdr_sel_t;
	// tap phase, one-hot
	typedef enum logic [4:0] {
		JTDR_PH_RESET = 5'h01,
		JTDR_PH_CAPTURE = 5'h02,
		JTDR_PH_SHIFT = 5'h04,
		JTDR_PH_UPDATE = 5'h08,
		JTDR_PH_OTHER = 5'h10
	} jtdr_phase_t;
endpackage

// *** rtl/jtdr_regs.sv ***
`timescale 1ns/1ns
`include "jtdr_consts.svh"
module jtdr_regs
	import jtdr_pkg::*;
#(
	parameter int CHAIN_LEN = `JTDR_CHAIN_LEN,
	parameter int ID_LEN = `JTDR_ID_LEN
)
(
	// system
	input wire logic clock,
	input wire logic rst,
	// test port pins (test clock domain)
	input wire logic scan_clock_pin,
	input wire logic scan_serial_in,
	output logic scan_serial_out,
	output logic scan_serial_out_oe_n,
	// tap state and current instruction from the controller
	input wire jtdr_phase_t tap_phase,
	input wire logic [2:0] instruction,
	// pin values as seen at the pads, cell order
	input wire logic [CHAIN_LEN-1:0] pad_capture,
	// latched parallel outputs of all cells
	output logic [CHAIN_LEN-1:0] cell_update,
	// decoded direction controls
	output logic data_bus_direction_cell,
	output logic irq_pin_direction_cell,
	output logic address_bus_direction_cell,
	// sampled control inputs as seen in the chain
	output logic hardware_reset_in,
	output logic bus_select_bit0,
	output logic bus_select_bit1,
	output logic bus_type_select,
	// latched id parallel stage
	output logic [ID_LEN-1:0] id_update
);
	jtdr_edge_if ev ();
	jtdr_sel_t sel; // which register sits in the serial path
	logic bypass_stage; // single bypass stage
	logic [ID_LEN-1:0] id_shift; // id shift stage
	logic [CHAIN_LEN-1:0] bsr_shift; // boundary shift stages, one per cell
	logic [CHAIN_LEN-1:0] bsr_update; // boundary latch stages
	logic [ID_LEN-1:0] id_code; // fixed identification value
	logic next_tdo; // value to present at the serial output

	// pin sampler feeding edge events
	jtdr_sampler u_sampler
	(
		.clock(clock),
		.rst(rst),
		.tck_pin(scan_clock_pin),
		.tdi_pin(scan_serial_in),
		.ev(ev)
	);

	// id code layout, lsb marker first
	assign id_code = {`JTDR_ID_VER, `JTDR_ID_DEV, `JTDR_ID_MFR, `JTDR_ID_MARK};

	// register selection from instruction and tap phase
	always_comb
	begin
		if (tap_phase == JTDR_PH_RESET || instruction == `JTDR_IR_IDCODE)
			sel = JTDR_SEL_ID;
		else if (instruction == `JTDR_IR_EXTEST || instruction == `JTDR_IR_SAMPLE)
			sel = JTDR_SEL_BSR;
		else
			sel = JTDR_SEL_BYP;
	end

	// bypass stage: zero on capture, one stage in shift
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			bypass_stage <= 1'h0;
		else if (ev.rise && sel == JTDR_SEL_BYP)
		begin
			// a fixed zero leads the data, so a tester can count devices
			if (tap_phase == JTDR_PH_CAPTURE)
				bypass_stage <= 1'h0;
			else if (tap_phase == JTDR_PH_SHIFT)
				bypass_stage <= ev.tdi;
		end
	end

	// id shift stage: load code on capture, shift toward bit 0
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			id_shift <= '0;
		else if (ev.rise && sel == JTDR_SEL_ID)
		begin
			if (tap_phase == JTDR_PH_CAPTURE || tap_phase == JTDR_PH_RESET)
				id_shift <= id_code;
			else if (tap_phase == JTDR_PH_SHIFT)
				id_shift <= {ev.tdi, id_shift[ID_LEN-1:1]};
		end
	end

	// id latch stage follows update on the falling edge
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			id_update <= '0;
		else if (tap_phase == JTDR_PH_RESET)
			id_update <= id_code; // forced during logic reset
		else if (ev.fall && tap_phase == JTDR_PH_UPDATE && sel == JTDR_SEL_ID)
			id_update <= id_shift;
	end

	// boundary shift: capture pads, then shift with cell 0 out first
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			bsr_shift <= '0;
		else if (ev.rise && sel == JTDR_SEL_BSR)
		begin
			if (tap_phase == JTDR_PH_CAPTURE)
				bsr_shift <= pad_capture;
			else if (tap_phase == JTDR_PH_SHIFT)
				bsr_shift <= {ev.tdi, bsr_shift[CHAIN_LEN-1:1]};
		end
	end

	// boundary latch on the falling edge in update; holds otherwise
	// so a long shift never disturbs the pins
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			bsr_update <= '0;
		else if (ev.fall && tap_phase == JTDR_PH_UPDATE && sel == JTDR_SEL_BSR)
			bsr_update <= bsr_shift;
	end

	assign cell_update = bsr_update;

	// direction and pinless control cells
	assign data_bus_direction_cell = bsr_update[`JTDR_POS_BUS_DIR];
	assign irq_pin_direction_cell = bsr_update[`JTDR_POS_IRQ_DIR];
	assign address_bus_direction_cell = bsr_update[`JTDR_POS_ADR_DIR];

	// sampled control inputs, as held in the shift stages
	assign hardware_reset_in = bsr_shift[`JTDR_POS_HWRST];
	assign bus_select_bit0 = bsr_shift[`JTDR_POS_SEL0];
	assign bus_select_bit1 = bsr_shift[`JTDR_POS_SEL1];
	assign bus_type_select = bsr_shift[`JTDR_POS_BTYPE];

	// serial output mux: lowest stage of the selected register
	always_comb
	begin
		unique case (sel)
			JTDR_SEL_ID: next_tdo = id_shift[0];
			JTDR_SEL_BSR: next_tdo = bsr_shift[0];
			JTDR_SEL_BYP: next_tdo = bypass_stage;
			default: next_tdo = bypass_stage;
		endcase
	end

	// output changes on the falling edge, enabled only in shift
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			scan_serial_out <= 1'h0;
			scan_serial_out_oe_n <= 1'h1;
		end
		else if (ev.fall)
		begin
			scan_serial_out <= next_tdo;
			scan_serial_out_oe_n <= (tap_phase != JTDR_PH_SHIFT);
		end
	end
endmodule

// *** rtl/jtdr_sampler.sv ***
`timescale 1ns/1ns
// three-stage sampler for pins from the test clock domain
module jtdr_sampler
(
	// system
	input wire logic clock,
	input wire logic rst,
	// pins
	input wire logic tck_pin,
	input wire logic tdi_pin,
	// edge events
	jtdr_edge_if.src ev
);
	logic [2:0] tck_sync; // stage 0 only feeds stage 1
	logic [2:0] tdi_sync;
	logic tck_state; // accepted clock level
	logic tdi_state;

	// shift pins through three flops
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tck_sync <= 3'h0;
			tdi_sync <= 3'h0;
		end
		else
		begin
			tck_sync <= {tck_sync[1:0], tck_pin};
			tdi_sync <= {tdi_sync[1:0], tdi_pin};
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tck_state <= 1'h0;
			tdi_state <= 1'h0;
		end
		else
		begin
			if (tck_sync[1] == tck_sync[2])
				tck_state <= tck_sync[2];
			if (tdi_sync[1] == tdi_sync[2])
				tdi_state <= tdi_sync[2];
		end
	end

	assign ev.rise = (tck_sync[1] == tck_sync[2]) && tck_sync[2] && !tck_state;
	assign ev.fall = (tck_sync[1] == tck_sync[2]) && !tck_sync[2] && tck_state;
	assign ev.tdi = tdi_state;
endmodule

// *** testbench/jtdr_regs_assertions.sv ***
`timescale 1ns/1ns
`include "jtdr_consts.svh"
module jtdr_regs_chk
	import jtdr_pkg::*;
#(
	parameter int CHAIN_LEN = 68,
	parameter int ID_LEN = 32
)
(
	// system
	input wire logic clock,
	input wire logic rst,
	// controller state
	input wire jtdr_phase_t tap_phase,
	// latched and sampled outputs
	input wire logic [CHAIN_LEN-1:0] cell_update,
	input wire logic data_bus_direction_cell,
	input wire logic irq_pin_direction_cell,
	input wire logic address_bus_direction_cell,
	input wire logic hardware_reset_in,
	input wire logic bus_select_bit0,
	input wire logic bus_select_bit1,
	input wire logic bus_type_select,
	input wire logic [ID_LEN-1:0] id_update
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// direction controls must follow their latch cells every cycle
	bus_dir_a: assert property (data_bus_direction_cell == cell_update[`JTDR_POS_BUS_DIR])
		else $error("data bus direction off its cell");
	irq_dir_a: assert property (irq_pin_direction_cell == cell_update[`JTDR_POS_IRQ_DIR])
		else $error("irq direction off its cell");
	adr_dir_a: assert property (address_bus_direction_cell == cell_update[`JTDR_POS_ADR_DIR])
		else $error("address direction off its cell");
	// direction cells may only move through the update latch
	dir_move_a: assert property ($changed({data_bus_direction_cell, irq_pin_direction_cell,
		address_bus_direction_cell}) |-> $past(tap_phase) == JTDR_PH_UPDATE)
		else $error("direction cell moved outside update");
	// two quiet cycles cover the edge pipeline, so no late latch slips past
	upd_hold_a: assert property (tap_phase != JTDR_PH_UPDATE && $past(tap_phase) != JTDR_PH_UPDATE
		|=> $stable(cell_update)) else $error("cell latch moved outside update");
	id_hold_a: assert property (!(tap_phase inside {JTDR_PH_UPDATE, JTDR_PH_RESET})
		&& !($past(tap_phase) inside {JTDR_PH_UPDATE, JTDR_PH_RESET}) |=> $stable(id_update))
		else $error("id latch moved outside update");
	samp_hold_a: assert property (tap_phase inside {JTDR_PH_UPDATE, JTDR_PH_OTHER}
		&& $past(tap_phase) inside {JTDR_PH_UPDATE, JTDR_PH_OTHER}
		|=> $stable({hardware_reset_in, bus_select_bit0, bus_select_bit1, bus_type_select}))
		else $error("sampled inputs moved while idle");
	id_reset_a: assert property (tap_phase == JTDR_PH_RESET [*3]
		|-> id_update == {`JTDR_ID_VER, `JTDR_ID_DEV, `JTDR_ID_MFR, `JTDR_ID_MARK})
		else $error("id code not forced in logic reset");
	rst_clear_a: assert property ($fell(rst) |-> cell_update == '0 && !hardware_reset_in)
		else $error("latch not cleared by reset");
endmodule
bind jtdr_regs jtdr_regs_chk #(.CHAIN_LEN(CHAIN_LEN), .ID_LEN(ID_LEN)) u_chk (.clock(clock),
	.rst(rst), .tap_phase(tap_phase), .cell_update(cell_update),
	.data_bus_direction_cell(data_bus_direction_cell), .irq_pin_direction_cell(irq_pin_direction_cell),
	.address_bus_direction_cell(address_bus_direction_cell), .hardware_reset_in(hardware_reset_in),
	.bus_select_bit0(bus_select_bit0), .bus_select_bit1(bus_select_bit1),
	.bus_type_select(bus_type_select), .id_update(id_update));

// *** testbench/jtdr_tester.sv ***
`timescale 1ns/1ns
module jtdr_tester
	import jtdr_pkg::*;
(
	// system
	input wire logic clock,
	// test port
	output logic tck,
	output logic tdi,
	output jtdr_phase_t phase,
	input wire logic tdo,
	input wire logic oe_n
);
	// test clock parked low, as between frames
	initial
	begin
		tck = 1'b0;
		tdi = 1'b0;
		phase = JTDR_PH_OTHER;
	end
	// leave the frame: clock stops low, data line no longer meaningful
	task park(input jtdr_phase_t p);
		phase <= p;
		tck <= 1'b0;
		tdi <= ~tdi;
		repeat (6) @(posedge clock);
	endtask
	// one state of 160 ns: fall inside it, then the rise that leaves it
	task step(input jtdr_phase_t p, input logic d, inout logic q);
		phase <= p;
		tdi <= d;
		tck <= 1'b0;
		repeat (4) @(posedge clock);
		tck <= 1'b1;
		@(negedge clock);
		// an undriven output is read as garbage, not as the last bit
		q = oe_n ? ~q : tdo;
		repeat (4) @(posedge clock);
	endtask
	// capture, n shifts taking one bit per rise, then update
	task scan(input logic [67:0] din, input int n, output logic [67:0] dout);
		logic q;
		dout = '0;
		q = 1'b0;
		step(JTDR_PH_CAPTURE, 1'b0, q);
		for (int k = 0; k < n; k++)
		begin
			step(JTDR_PH_SHIFT, din[k], q);
			dout[k] = q;
		end
		step(JTDR_PH_UPDATE, 1'b0, q);
		park(JTDR_PH_OTHER);
	endtask
endmodule

// *** testbench/test_jtdr_regs.sv ***
`timescale 1ns/1ns
`include "jtdr_consts.svh"
module test_jtdr_regs
	import jtdr_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic tck, tdi, so, oe_n, bdir, idir, adir, hr, bs0, bs1, bt;
	jtdr_phase_t ph;
	logic [2:0] instr = 3'h7;
	logic [2:0] byp [5] = '{3'h7, 3'h1, 3'h4, 3'h5, 3'h6};
	logic [67:0] pads = '0;
	logic [67:0] cu, din, dout;
	logic [31:0] idu;
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 36;
	always #10 clock = ~clock;
	jtdr_tester u_tst (.clock(clock), .tck(tck), .tdi(tdi), .phase(ph), .tdo(so), .oe_n(oe_n));
	jtdr_regs u_dut (.clock(clock), .rst(rst), .scan_clock_pin(tck), .scan_serial_in(tdi),
		.scan_serial_out(so), .scan_serial_out_oe_n(oe_n), .tap_phase(ph), .instruction(instr),
		.pad_capture(pads), .cell_update(cu), .data_bus_direction_cell(bdir),
		.irq_pin_direction_cell(idir), .address_bus_direction_cell(adir),
		.hardware_reset_in(hr), .bus_select_bit0(bs0), .bus_select_bit1(bs1),
		.bus_type_select(bt), .id_update(idu));
	// expected code from the arbitrary field values
	function automatic logic [31:0] id_exp();
		return {`JTDR_ID_VER, `JTDR_ID_DEV, `JTDR_ID_MFR, `JTDR_ID_MARK};
	endfunction
	// one-stage path: a captured zero leads the data
	function automatic logic [7:0] byp_exp(input logic [7:0] d);
		return {d[6:0], 1'b0};
	endfunction
	task chk(input string n, input logic [67:0] e, input logic [67:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task close_out;
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// a hang counts against the run
	initial
	begin
		repeat (90000) @(posedge clock);
		fail_count++;
		close_out;
	end
	initial
	begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		u_tst.park(JTDR_PH_RESET);
		chk("reset id", 68'(id_exp()), 68'(idu));
		u_tst.park(JTDR_PH_OTHER);
		instr <= 3'h3;
		din = 68'({$random(seed), $random(seed), $random(seed)});
		u_tst.scan(din, 32, dout);
		chk("id out", 68'(id_exp()), 68'(dout[31:0]));
		chk("id latch", 68'(din[31:0]), 68'(idu));
		// bypass, and codes with no register of their own
		foreach (byp[i])
		begin
			instr <= byp[i];
			din = 68'({$random(seed), $random(seed), $random(seed)});
			u_tst.scan(din, 8, dout);
			chk("bypass", 68'(byp_exp(din[7:0])), 68'(dout[7:0]));
		end
		// full chain: all-ones pads, all-zero load, then random
		for (int i = 0; i < 4; i++)
		begin
			instr <= i[0] ? 3'h2 : 3'h0;
			pads <= (i == 0) ? '1 : 68'({$random(seed), $random(seed), $random(seed)});
			din = (i == 1) ? '0 : 68'({$random(seed), $random(seed), $random(seed)});
			u_tst.scan(din, 68, dout);
			chk("capture", pads, dout);
			chk("update", din, cu);
			chk("dirs", 68'({din[54], din[39], din[61]}), 68'({bdir, idir, adir}));
			chk("inputs", 68'({din[36], din[35], din[55], din[34]}), 68'({hr, bs0, bs1, bt}));
		end
		close_out;
	end
endmodule
